// >>> inc/chgsel_pkg.sv
// Package of constants and types for the charger source selector
// How it works
// [RULE_01] High priority select uses adapter; USB only when adapter absent.
// [RULE_02] High priority select with both inputs present picks the adapter.
// [RULE_03] Low select, USB absent, adapter present: adapter at USB rate limit.
// [RULE_04] Low select with USB present uses USB regardless of adapter.
// [RULE_05] No input present: battery powers system, no charging.
// [RULE_06] Adapter with high select uses main rate; USB always USB rate.
// [RULE_07] Input present only when above battery; its power-good goes low.
// [RULE_08] Overvoltage variant: adapter with switch opened by overvoltage is absent.
// [RULE_09] Overvoltage variant opens adapter switch above cut-off level.
// [RULE_10] At power-up force 100 mA USB rate about 150 ms, ignoring inputs.
// [RULE_11] After boot-up interval honour charge enable and USB rate select.
// [RULE_12] Boot override only with low select and some input present.
// [RULE_13] Single-status variant: combined power-good low when either input present.
// [RULE_14] Single-status variant takes charge voltage select instead of USB power-good.
// [RULE_15] Adapter mode keeps USB switch open.
// [RULE_16] Output sag to droop guard reduces charge current; system served first.
// [RULE_17] Output below battery closes battery switch to supplement input.
// [RULE_18] Reduced charge current slows safety timer proportionally; half level doubles.
// [RULE_19] USB rate select high means 500 mA, low means 100 mA.
// [RULE_20] Timer program tied to regulator disables safety timer and termination.
// [RULE_21] Open active source switch before closing the replacement switch.
// [RULE_22] Boot interval timed by counter from reset; force ends at count end.
// [RULE_23] Re-evaluate selection on any select or presence change, break-before-make.
package chgsel_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BOOT_MS = 150;
  localparam int unsigned BOOT_CYCLES = (CLK_HZ / 1000) * BOOT_MS;
  localparam int unsigned BREAK_US = 10;
  localparam int unsigned BREAK_CYCLES = (CLK_HZ / 1000000) * BREAK_US;
  localparam int unsigned TIMER_BASE_CYCLES = 16;
  localparam int unsigned PROG_W = 8;
  localparam logic [7:0] PROG_NOMINAL = 8'h80;
  localparam int unsigned RATE_USB100_MA = 100;
  localparam int unsigned RATE_USB500_MA = 500;
  typedef enum logic [1:0] {
    CHGSEL_SRC_BAT,
    CHGSEL_SRC_AC,
    CHGSEL_SRC_USB
  } chgsel_src_t;
  typedef enum logic [1:0] {
    CHGSEL_RATE_NONE,
    CHGSEL_RATE_MAIN,
    CHGSEL_RATE_USB100,
    CHGSEL_RATE_USB500
  } chgsel_rate_t;
endpackage

// >>> inc/chgsel_tmr_if.sv
// Interface between the selector and its safety timer
`timescale 1ns/1ps
`default_nettype none
interface chgsel_tmr_if;
  import chgsel_pkg::*;
  logic run;
  logic disable_timer;
  logic [PROG_W-1:0] level;
  logic tick;
  modport ctrl(output run, output disable_timer, output level, input tick);
  modport timer(input run, input disable_timer, input level, output tick);
endinterface
`default_nettype wire

// >>> core/chgsel_safety_tick.sv
// Safety timer clock whose rate follows the program level
`timescale 1ns/1ps
`default_nettype none
module chgsel_safety_tick
  import chgsel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  chgsel_tmr_if.timer tif
);
  logic [PROG_W+7:0] acc_q;
  logic [PROG_W+7:0] acc_d;
  logic tick_q;
  localparam logic [PROG_W+7:0] WRAP = (PROG_W+8)'(PROG_NOMINAL) * (PROG_W+8)'(TIMER_BASE_CYCLES);
  wire active = tif.run && !tif.disable_timer;
  wire [PROG_W+7:0] sum = acc_q + (PROG_W+8)'(tif.level);
  wire wrap_hit = active && (sum >= WRAP);
  // Accumulating the level makes the tick rate proportional to it
  assign acc_d = !active ? acc_q : (wrap_hit ? sum - WRAP : sum); // RULE_18
  assign tif.tick = tick_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= wrap_hit; // RULE_20
    end
  end
endmodule
`default_nettype wire

// >>> core/chgsel_top.sv
// Source selection, boot-up rate override and power-path control
`timescale 1ns/1ps
`default_nettype none
module chgsel_top
  import chgsel_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES,
  parameter int unsigned BREAK_LEN = BREAK_CYCLES,
  parameter bit OVP_VARIANT = 1'b0,
  parameter bit SINGLE_STATUS = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic priority_select,
  input wire logic adapter_above_battery,
  input wire logic usb_above_battery,
  input wire logic adapter_over_cutoff,
  input wire logic usb_rate_select,
  input wire logic charge_enable,
  input wire logic charge_voltage_select,
  input wire logic out_at_droop_guard,
  input wire logic out_below_battery,
  input wire logic timer_tied_to_regulator,
  input wire logic [7:0] safety_timer_program,
  output logic adapter_switch,
  output logic usb_switch,
  output logic battery_switch,
  output logic charging,
  output logic [1:0] charge_rate,
  output logic charge_reduce,
  output logic adapter_power_good_n,
  output logic usb_power_good_n,
  output logic combined_power_good_n,
  output logic charge_voltage_high,
  output logic boot_force,
  output logic termination_enable,
  output logic safety_tick
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 11;
  wire [NS-1:0] raw = {priority_select, adapter_above_battery, usb_above_battery,
                       adapter_over_cutoff, usb_rate_select, charge_enable,
                       charge_voltage_select, out_at_droop_guard, out_below_battery,
                       timer_tied_to_regulator, 1'b0};
  wire [NS-1:0] lvl;
  logic [7:0] prog1_q;
  logic [7:0] prog2_q;
  // Two flops per asynchronous level before any logic reads it
  for (genvar g = 0; g < NS; g++) begin : g_sync
    logic m1_q;
    logic m2_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        m1_q <= 1'b0;
        m2_q <= 1'b0;
      end else begin
        m1_q <= raw[g];
        m2_q <= m1_q;
      end
    end
    assign lvl[g] = m2_q;
  end
  // Program word is quasi-static; a torn sample lasts one cycle at most
  always_ff @(posedge clk) begin
    if (rst) begin
      prog1_q <= '0;
      prog2_q <= '0;
    end else begin
      prog1_q <= safety_timer_program;
      prog2_q <= prog1_q;
    end
  end
  wire psel = lvl[10];
  wire ac_above = lvl[9];
  wire usb_above = lvl[8];
  wire ac_ovp = lvl[7];
  wire rate_sel = lvl[6];
  wire chg_en = lvl[5];
  wire vsel = lvl[4];
  wire droop = lvl[3];
  wire below_bat = lvl[2];
  wire tmr_off = lvl[1];

  // ----------------------------------------------------------------
  // Presence and source choice
  // ----------------------------------------------------------------
  logic ovp_open_q;
  wire ovp_open_d = OVP_VARIANT && ac_ovp; // RULE_09
  wire ac_present = ac_above && !ovp_open_q; // RULE_07 RULE_08
  wire usb_present = usb_above; // RULE_07

  function automatic chgsel_src_t pick_src(input logic sel, input logic ac, input logic usb);
    chgsel_src_t s;
    s = CHGSEL_SRC_BAT;
    if (sel) begin
      if (ac) s = CHGSEL_SRC_AC; // RULE_01 RULE_02
      else if (usb) s = CHGSEL_SRC_USB; // RULE_01
    end else begin
      if (usb) s = CHGSEL_SRC_USB; // RULE_04
      else if (ac) s = CHGSEL_SRC_AC; // RULE_03
    end
    return s; // RULE_05
  endfunction

  wire chgsel_src_t want = pick_src(psel, ac_present, usb_present); // RULE_23

  // ----------------------------------------------------------------
  // Break-before-make sequencer
  // ----------------------------------------------------------------
  typedef enum {CHGSEL_ST_ON, CHGSEL_ST_BREAK} chgsel_st_t;
  chgsel_st_t st_q;
  chgsel_st_t st_d;
  chgsel_src_t cur_q;
  chgsel_src_t cur_d;
  logic [15:0] brk_q;
  logic [15:0] brk_d;
  localparam logic [15:0] BRK_LAST = 16'(BREAK_LEN - 1);
  wire brk_done = brk_q >= BRK_LAST;
  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    brk_d = brk_q;
    unique case (st_q)
      CHGSEL_ST_ON: begin
        if (want != cur_q) begin
          // Open the live switch first; battery path holds the output meanwhile
          st_d = CHGSEL_ST_BREAK; // RULE_21 RULE_23
          cur_d = CHGSEL_SRC_BAT;
          brk_d = '0;
        end
      end
      CHGSEL_ST_BREAK: begin
        brk_d = brk_q + 16'h0001;
        if (brk_done) begin
          st_d = CHGSEL_ST_ON;
          cur_d = want; // RULE_21
          brk_d = '0;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= CHGSEL_ST_ON;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_q <= CHGSEL_SRC_BAT;
    end else begin
      cur_q <= cur_d;
    end
  end

  // Counts the interval in which neither source switch conducts
  always_ff @(posedge clk) begin
    if (rst) begin
      brk_q <= '0;
    end else begin
      brk_q <= brk_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovp_open_q <= 1'b0;
    end else begin
      ovp_open_q <= ovp_open_d;
    end
  end

  // ----------------------------------------------------------------
  // Boot-up rate override
  // ----------------------------------------------------------------
  logic [23:0] boot_cnt_q;
  logic boot_done_q;
  localparam logic [23:0] BOOT_LAST = 24'(BOOT_LEN - 1);
  wire boot_allowed = !psel && (ac_present || usb_present); // RULE_12
  wire boot_active = !boot_done_q && boot_allowed; // RULE_10
  // Counter and done flag freeze once the interval is over
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_cnt_q <= '0;
    end else if (!boot_done_q) begin
      boot_cnt_q <= boot_cnt_q + 24'h000001; // RULE_22
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_done_q <= 1'b0;
    end else if (!boot_done_q) begin
      boot_done_q <= boot_cnt_q >= BOOT_LAST; // RULE_22 RULE_11
    end
  end

  // ----------------------------------------------------------------
  // Charge rate and power path
  // ----------------------------------------------------------------
  // A source feeds the output only once the break interval is over
  function automatic logic feeds(input chgsel_st_t st, input chgsel_src_t cur,
    input chgsel_src_t src);
    return (st == CHGSEL_ST_ON) && (cur == src);
  endfunction
  wire on_ac = feeds(st_q, cur_q, CHGSEL_SRC_AC);
  wire on_usb = feeds(st_q, cur_q, CHGSEL_SRC_USB);
  wire have_src = on_ac || on_usb;
  wire use_main = on_ac && psel; // RULE_06
  wire chgsel_rate_t usb_rate = rate_sel ? CHGSEL_RATE_USB500 : CHGSEL_RATE_USB100; // RULE_19
  wire chgsel_rate_t rate_d = !have_src ? CHGSEL_RATE_NONE :
                              boot_active ? CHGSEL_RATE_USB100 : // RULE_10
                              use_main ? CHGSEL_RATE_MAIN : usb_rate; // RULE_03 RULE_06
  wire charging_d = have_src && (boot_active || chg_en); // RULE_05 RULE_11
  // Battery switch closes to charge, or to supplement a sagging output
  wire bat_sw_d = charging_d || below_bat || !have_src; // RULE_17 RULE_05
  wire reduce_d = charging_d && droop; // RULE_16
  wire [7:0] tmr_level = reduce_d ? prog2_q : PROG_NOMINAL; // RULE_18

  chgsel_tmr_if tif();
  assign tif.run = charging_d;
  assign tif.disable_timer = tmr_off; // RULE_20
  assign tif.level = tmr_level;
  chgsel_safety_tick u_tick (
    .clk(clk),
    .rst(rst),
    .tif(tif)
  );

  // ----------------------------------------------------------------
  // Power-path switch outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      adapter_switch <= 1'b0;
    end else begin
      adapter_switch <= on_ac; // RULE_15
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      usb_switch <= 1'b0;
    end else begin
      usb_switch <= on_usb; // RULE_15
    end
  end

  // Closed from reset so the system rides on the battery until a source is chosen
  always_ff @(posedge clk) begin
    if (rst) begin
      battery_switch <= 1'b1;
    end else begin
      battery_switch <= bat_sw_d; // RULE_17
    end
  end

  // ----------------------------------------------------------------
  // Charge control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      charging <= 1'b0;
    end else begin
      charging <= charging_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      charge_rate <= CHGSEL_RATE_NONE;
    end else begin
      charge_rate <= rate_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      charge_reduce <= 1'b0;
    end else begin
      charge_reduce <= reduce_d; // RULE_16
    end
  end

  // Flags the override only while a source really feeds the charger
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_force <= 1'b0;
    end else begin
      boot_force <= boot_active && have_src; // RULE_10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      termination_enable <= 1'b0;
    end else begin
      termination_enable <= charging_d && !tmr_off; // RULE_20
    end
  end

  // One-cycle pulse per safety timer step
  always_ff @(posedge clk) begin
    if (rst) begin
      safety_tick <= 1'b0;
    end else begin
      safety_tick <= tif.tick;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      adapter_power_good_n <= 1'b1;
    end else begin
      adapter_power_good_n <= !ac_present; // RULE_07
    end
  end

  // The single-status build holds this output high; voltage select comes in on charge_voltage_select
  always_ff @(posedge clk) begin
    if (rst) begin
      usb_power_good_n <= 1'b1;
    end else begin
      usb_power_good_n <= SINGLE_STATUS ? 1'b1 : !usb_present; // RULE_14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      combined_power_good_n <= 1'b1;
    end else begin
      combined_power_good_n <= !(ac_present || usb_present); // RULE_13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      charge_voltage_high <= 1'b0;
    end else begin
      charge_voltage_high <= SINGLE_STATUS && vsel; // RULE_14
    end
  end
endmodule
`default_nettype wire

// >>> sim/chgsel_top_sva.sv
// Port-level checks on the charger source selector
`timescale 1ns/1ps
`default_nettype none
module chgsel_top_sva #(
  parameter int unsigned BOOT_LEN = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic priority_select,
  input wire logic adapter_above_battery,
  input wire logic usb_above_battery,
  input wire logic adapter_over_cutoff,
  input wire logic out_at_droop_guard,
  input wire logic out_below_battery,
  input wire logic timer_tied_to_regulator,
  input wire logic adapter_switch,
  input wire logic usb_switch,
  input wire logic battery_switch,
  input wire logic charging,
  input wire logic [1:0] charge_rate,
  input wire logic charge_reduce,
  input wire logic adapter_power_good_n,
  input wire logic boot_force,
  input wire logic termination_enable,
  input wire logic safety_tick
);
  // ----------------------------------------
  // Cycles since reset, saturating
  // ----------------------------------------
  logic [31:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) cnt_q <= 32'h0;
    else if (cnt_q < 32'hffff) cnt_q <= cnt_q + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_switch_exclusive: assert property (!(adapter_switch && usb_switch))
    else $error("Both source switches closed");
  a_break_gap: assert property ($fell(usb_switch) |-> !adapter_switch [*3])
    else $error("Adapter switch closed too soon");
  a_main_rate_ac: assert property ((charge_rate == 2'h1) |-> !usb_switch)
    else $error("Main rate while on USB");
  a_ac_blocks_usb: assert property ((priority_select && adapter_above_battery && !adapter_over_cutoff) [*8] |-> !usb_switch)
    else $error("USB switch closed in adapter mode");
  a_ac_good: assert property ((adapter_above_battery && !adapter_over_cutoff) [*6] |-> !adapter_power_good_n)
    else $error("Adapter power good missing");
  a_ovp_off: assert property (adapter_over_cutoff [*6] |-> (adapter_power_good_n && !adapter_switch))
    else $error("Adapter kept above cut-off");
  a_none_battery: assert property ((!adapter_above_battery && !usb_above_battery) [*6] |-> (battery_switch && !charging))
    else $error("No input yet not on battery");
  a_boot_gate: assert property (priority_select [*6] |-> !boot_force)
    else $error("Boot override with high select");
  a_boot_rate: assert property (boot_force |-> (charging && charge_rate == 2'h2))
    else $error("Boot override rate wrong");
  a_boot_end: assert property ((cnt_q > BOOT_LEN + 4) |-> !boot_force)
    else $error("Boot override too long");
  a_timer_off: assert property (timer_tied_to_regulator [*6] |-> (!safety_tick && !termination_enable))
    else $error("Timer active while disabled");
  a_supplement: assert property (out_below_battery [*6] |-> battery_switch)
    else $error("Battery switch open under overload");
  a_droop: assert property ((out_at_droop_guard && charging) [*6] |-> charge_reduce)
    else $error("Charge not reduced at droop");
  c_ac_on: cover property ($rose(adapter_switch));
  c_usb_on: cover property ($rose(usb_switch));
  c_reduce: cover property ($rose(charge_reduce));
endmodule
bind chgsel_top chgsel_top_sva #(.BOOT_LEN(BOOT_LEN)) i_sva (.clk, .rst, .priority_select,
  .adapter_above_battery, .usb_above_battery, .adapter_over_cutoff, .out_at_droop_guard,
  .out_below_battery, .timer_tied_to_regulator, .adapter_switch, .usb_switch, .battery_switch,
  .charging, .charge_rate, .charge_reduce, .adapter_power_good_n, .boot_force,
  .termination_enable, .safety_tick);
`default_nettype wire

// >>> sim/chgsel_supply_model.sv
// Model of the supplies and system load around the selector
`timescale 1ns/1ps
`default_nettype none
module chgsel_supply_model (
  input wire logic ac_on,
  input wire logic ac_hi,
  input wire logic usb_on,
  input wire logic [1:0] load,
  output logic adapter_above_battery,
  output logic usb_above_battery,
  output logic adapter_over_cutoff,
  output logic out_at_droop_guard,
  output logic out_below_battery
);
  assign adapter_above_battery = ac_on;
  assign usb_above_battery = usb_on;
  assign adapter_over_cutoff = ac_on && ac_hi;
  // Heavier load sags to the guard first, then below the battery
  assign out_at_droop_guard = load != 2'h0;
  assign out_below_battery = load == 2'h2;
endmodule
`default_nettype wire

// >>> sim/chgsel_top_tb.sv
// Self-checking bench for the charger source selector
`timescale 1ns/1ps
`default_nettype none
module chgsel_top_tb;
  import chgsel_pkg::*;
  localparam int unsigned BOOT = 50;
  localparam int unsigned BRK = 4;
  logic clk = 1'b0, rst = 1'b1, priority_select = 1'b0, usb_rate_select = 1'b1;
  logic charge_enable = 1'b0, timer_tied_to_regulator = 1'b0;
  logic ac_on = 1'b0, ac_hi = 1'b0, usb_on = 1'b1, ac_sel, usb_sel;
  logic [1:0] load = 2'h0;
  logic [7:0] safety_timer_program = 8'h80;
  logic adapter_above_battery, usb_above_battery, adapter_over_cutoff, out_at_droop_guard;
  logic out_below_battery, adapter_switch, usb_switch, battery_switch, charging, charge_reduce;
  logic adapter_power_good_n, usb_power_good_n, boot_force, termination_enable, safety_tick;
  logic combined_power_good_n;
  logic [1:0] charge_rate;
  int failures = 0, checks = 0, n;
  chgsel_supply_model i_sup (.ac_on, .ac_hi, .usb_on, .load, .adapter_above_battery,
    .usb_above_battery, .adapter_over_cutoff, .out_at_droop_guard, .out_below_battery);
  chgsel_top #(.BOOT_LEN(BOOT), .BREAK_LEN(BRK), .OVP_VARIANT(1'b1)) i_dut (.clk, .rst,
    .priority_select, .adapter_above_battery, .usb_above_battery, .adapter_over_cutoff,
    .usb_rate_select, .charge_enable, .charge_voltage_select(1'b0), .out_at_droop_guard,
    .out_below_battery, .timer_tied_to_regulator, .safety_timer_program, .adapter_switch,
    .usb_switch, .battery_switch, .charging, .charge_rate, .charge_reduce,
    .adapter_power_good_n, .usb_power_good_n, .combined_power_good_n, .charge_voltage_high(),
    .boot_force, .termination_enable, .safety_tick);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic ticks(output int t);
    t = 0;
    repeat (320) begin
      @(negedge clk);
      if (safety_tick === 1'b1) t++;
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    step(20000);
    failures++;
    summarize();
  end
  initial begin
    step(20);
    rst = 1'b0;
    step(10);
    chk({boot_force, charging, charge_rate}, 4'he);
    n = 0;
    while (boot_force === 1'b1 && n < BOOT + 20) begin
      step(1);
      n++;
    end
    if (n >= BOOT + 20) begin
      failures++;
      summarize();
    end
    step(5);
    chk(charging, 1'b0);
    charge_enable = 1'b1;
    step(5);
    chk(charge_rate, 2'h3);
    $display("test boot done");
    for (int i = 0; i < 16; i++) begin
      {usb_rate_select, usb_on, ac_on, priority_select} = i[3:0];
      step(16);
      ac_sel = priority_select ? ac_on : (ac_on && !usb_on);
      usb_sel = priority_select ? (usb_on && !ac_on) : usb_on;
      chk({adapter_switch, usb_switch}, {ac_sel, usb_sel});
      chk(charge_rate, (ac_sel && priority_select) ? 2'h1 :
        (ac_sel || usb_sel) ? {1'b1, usb_rate_select} : 2'h0);
      chk({charging, adapter_power_good_n, usb_power_good_n, combined_power_good_n},
        {ac_on | usb_on, ~ac_on, ~usb_on, ~(ac_on | usb_on)});
    end
    $display("test selection table done");
    {priority_select, ac_on, usb_on} = 3'b101;
    step(16);
    ac_on = 1'b1;
    n = 0;
    repeat (30) begin
      step(1);
      if (adapter_switch === 1'b0 && usb_switch === 1'b0) n++;
    end
    chk(4'(n), 4'(BRK));
    ac_hi = 1'b1;
    step(16);
    chk({adapter_power_good_n, adapter_switch, usb_switch}, 3'b101);
    {ac_hi, usb_on} = 2'b00;
    $display("test break and cut-off done");
    step(16);
    ticks(n);
    chk(n >= 19 && n <= 21, 1'b1);
    chk(termination_enable, 1'b1);
    {load, safety_timer_program} = {2'h1, 8'h40};
    step(16);
    chk(charge_reduce, 1'b1);
    ticks(n);
    chk(n >= 9 && n <= 11, 1'b1);
    {load, charge_enable} = 3'b100;
    step(16);
    chk(battery_switch, 1'b1);
    load = 2'h0;
    step(16);
    chk(battery_switch, 1'b0);
    {charge_enable, timer_tied_to_regulator} = 2'b11;
    step(16);
    ticks(n);
    chk({n == 0, termination_enable}, 2'b10);
    $display("test droop and timer done");
    summarize();
  end
endmodule
`default_nettype wire
